/* File: dpss_pkg.sv */
// Purpose: Shared constants and types of the DP slave start-up and parameter decoder.
// Assumes: One 100 MHz clock; telegrams arrive already deframed from the link layer.
// Notes:   Offsets are byte addresses on the AHB-Lite register port.
package dpss_pkg;

  typedef enum logic [1:0] {
    ST_POWER_ON  = 2'b00,
    ST_WAIT_PRM  = 2'b01,
    ST_WAIT_CFG  = 2'b11,
    ST_DATA_EXCH = 2'b10
  } dpss_state_t;

  typedef enum logic [2:0] {
    RSP_NONE = 3'h0,
    RSP_ACK  = 3'h1,
    RSP_DIAG = 3'h2,
    RSP_CFG  = 3'h3,
    RSP_DATA = 3'h4
  } dpss_rsp_t;

  localparam logic [7:0] SAP_GET_CFG = 8'h3b;
  localparam logic [7:0] SAP_DIAG    = 8'h3c;
  localparam logic [7:0] SAP_SET_PRM = 8'h3d;
  localparam logic [7:0] SAP_CHK_CFG = 8'h3e;

  localparam logic [7:0] MASTER_NONE = 8'hff;
  localparam logic [7:0] PRM_STD_LEN = 8'd10;
  localparam logic [7:0] BLK_FIRST   = 8'd11;
  localparam logic [7:0] ISO_LEN     = 8'd28;
  localparam logic [7:0] ISO_TYPE    = 8'h04;
  localparam logic [7:0] ISO_VERSION = 8'h01;
  localparam int         CFG_MAX     = 4;

  localparam int O1_WD_ON   = 3;
  localparam int O1_FREEZE  = 4;
  localparam int O1_SYNC    = 5;
  localparam int O8_FAILSAFE = 6;
  localparam int O8_DPV1     = 7;
  localparam int O9_DIAG_ALM = 5;
  localparam int O10_STRUCT  = 3;
  localparam int O10_ISOM    = 4;

  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_STATUS  = 8'h04;
  localparam logic [7:0] REG_PRM_A   = 8'h08;
  localparam logic [7:0] REG_PRM_B   = 8'h0c;
  localparam logic [7:0] REG_PRM_C   = 8'h10;
  localparam logic [7:0] REG_TB_DP   = 8'h14;
  localparam logic [7:0] REG_TB_IO   = 8'h18;
  localparam logic [7:0] REG_CFG_EXP = 8'h1c;
  localparam logic [7:0] REG_CFG_LEN = 8'h20;

  localparam logic [31:0] CFG_EXP_RST = 32'h0000_0000;
  localparam logic [2:0]  CFG_LEN_RST = 3'h0;

  // Time bases in units of 1/12 us that the isochronous block may carry.
  function automatic logic tbase_ok(input logic [31:0] v);
    return (v == 32'd375) || (v == 32'd750) || (v == 32'd1500) ||
           (v == 32'd3000) || (v == 32'd6000) || (v == 32'd12000);
  endfunction

endpackage

/* File: dpss_cfg_match.sv */
// Purpose: Compares the octets of a configuration check telegram with the expected list.
// Assumes: start_i precedes the octets of one telegram; same clock as the octet source.
// Notes:   match_o is valid from the cycle after the last octet until the next start_i.
`timescale 1ns/100ps
module dpss_cfg_match (
  input  wire logic                          ref_clk_i,
  input  wire logic                          rstn_i,
  input  wire logic                          start_i,
  input  wire logic                          oct_valid_i,
  input  wire logic [7:0]                    oct_data_i,
  input  wire logic [8*dpss_pkg::CFG_MAX-1:0] exp_cfg_i,
  input  wire logic [2:0]                    exp_len_i,
  output logic                               match_o
);
  import dpss_pkg::*;

  typedef struct packed {
    logic [3:0] cnt;
    logic       ok;
  } dpss_cm_st_t;

  dpss_cm_st_t q;
  dpss_cm_st_t d;

  always_comb begin
    d = q;
    if (start_i) begin
      d.cnt = 4'h0;
      d.ok  = 1'b1;
    end else if (oct_valid_i) begin
      if ((q.cnt >= {1'b0, exp_len_i}) ||
          (oct_data_i != exp_cfg_i[{q.cnt[1:0], 3'b000} +: 8])) begin
        d.ok = 1'b0;
      end
      if (q.cnt != 4'hf) begin
        d.cnt = q.cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign match_o = q.ok && (q.cnt == {1'b0, exp_len_i});

endmodule

/* File: dpss_startup.sv */
// Purpose: Start-up state machine and parameter telegram decoder of a DP slave.
// Assumes: Frame start, octets and frame end come as separate cycles from the link layer.
// Notes:   Register port is a zero-wait AHB-Lite slave; every answer is OKAY.
//
// The implementer's own choices: the address map and register access over AHB-Lite.
`timescale 1ns/100ps
module dpss_startup #(
  // Identification number; the value is arbitrary.
  parameter logic [15:0] IDENT_NUMBER = 16'h5a17
) (
  input  wire logic                ref_clk_i,
  input  wire logic                rstn_i,
  input  wire logic                frm_sof_i,
  input  wire logic [7:0]          frm_sap_i,
  input  wire logic                frm_dflt_i,
  input  wire logic [7:0]          frm_master_i,
  input  wire logic                oct_valid_i,
  input  wire logic [7:0]          oct_data_i,
  input  wire logic                frm_eof_i,
  input  wire logic [31:0]         position_i,
  output logic                     rsp_valid_o,
  output dpss_pkg::dpss_rsp_t      rsp_kind_o,
  output logic [31:0]              rsp_data_o,
  output dpss_pkg::dpss_state_t    state_o,
  output logic                     data_exch_o,
  output logic                     wd_on_o,
  output logic                     freeze_req_o,
  output logic                     sync_req_o,
  output logic                     iso_mode_o,
  input  wire logic                hsel_i,
  input  wire logic [31:0]         haddr_i,
  input  wire logic [1:0]          htrans_i,
  input  wire logic                hwrite_i,
  input  wire logic [2:0]          hsize_i,
  input  wire logic [31:0]         hwdata_i,
  input  wire logic                hready_i,
  output logic                     hreadyout_o,
  output logic                     hresp_o,
  output logic [31:0]              hrdata_o
);
  import dpss_pkg::*;

  typedef struct packed {
    dpss_state_t     st;
    logic [7:0]      master;
    logic            prm_fault;
    logic            cfg_fault;
    logic [9:0][7:0] prm;
    logic [31:0]     tb_dp;
    logic [31:0]     tb_io;
    logic            iso_on;
    logic            busy;
    logic [7:0]      sap;
    logic            dflt;
    logic [7:0]      rmaster;
    logic [7:0]      idx;
    logic [9:0][7:0] stg;
    logic [31:0]     stg_dp;
    logic [31:0]     stg_io;
    logic [7:0]      blk_base;
    logic [7:0]      blk_end;
    logic            iso_in;
    logic            iso_seen;
    logic            bad;
    logic            rsp_v;
    dpss_rsp_t       rsp_k;
    logic [31:0]     rsp_d;
    logic            wr_pend;
    logic [7:0]      wr_addr;
    logic [31:0]     rdata;
    logic [31:0]     cfg_exp;
    logic [2:0]      cfg_len;
  } dpss_main_st_t;

  dpss_main_st_t q;
  dpss_main_st_t d;
  logic          cfg_match;

  dpss_cfg_match u_cfg_match (
    .ref_clk_i   (ref_clk_i),
    .rstn_i      (rstn_i),
    .start_i     (frm_sof_i),
    .oct_valid_i (oct_valid_i),
    .oct_data_i  (oct_data_i),
    .exp_cfg_i   (q.cfg_exp),
    .exp_len_i   (q.cfg_len),
    .match_o     (cfg_match)
  );

  // Checks the staged standard, DP-V1 and isochronous fields.
  function automatic logic prm_ok(input dpss_main_st_t s, input logic [15:0] ident);
    logic ok;
    ok = !s.bad && (s.idx >= PRM_STD_LEN);
    ok = ok && (s.stg[0][2:0] == 3'h0);
    ok = ok && ({s.stg[4], s.stg[5]} == ident);
    ok = ok && s.stg[7][O8_FAILSAFE];
    ok = ok && (s.stg[8][4:1] == 4'h0) && (s.stg[8][7:6] == 2'h0);
    ok = ok && (s.stg[7][O8_DPV1] || !s.stg[8][O9_DIAG_ALM]);
    ok = ok && (s.stg[9][2:0] == 3'h0) && s.stg[9][O10_STRUCT];
    ok = ok && (s.stg[9][7:5] == 3'h0);
    ok = ok && ((s.idx < BLK_FIRST) || (s.blk_base == s.idx + 8'd1));
    if (s.stg[9][O10_ISOM]) begin
      ok = ok && s.iso_seen && tbase_ok(s.stg_dp) && tbase_ok(s.stg_io);
    end
    return ok;
  endfunction

  logic [7:0] n;
  logic [7:0] off;
  logic [8:0] end_sum;
  logic       bound;
  logic       restart;
  logic       ahb_go;
  logic [31:0] rmux;

  always_comb begin
    d       = q;
    n       = q.idx + 8'd1;
    off     = n - q.blk_base;
    end_sum = {1'b0, n} + {1'b0, oct_data_i} - 9'd1;
    bound   = (q.master == q.rmaster) && (q.master != MASTER_NONE);
    restart = 1'b0;
    rmux    = 32'h0000_0000;
    d.rsp_v = 1'b0;
    d.rsp_k = RSP_NONE;

    if (q.st == ST_POWER_ON) begin
      d.st = ST_WAIT_PRM;
    end

    // Request header: the access point picks the service.
    if (frm_sof_i) begin
      d.busy     = 1'b1;
      d.sap      = frm_sap_i;
      d.dflt     = frm_dflt_i;
      d.rmaster  = frm_master_i;
      d.idx      = 8'h00;
      d.blk_base = BLK_FIRST;
      d.blk_end  = 8'h00;
      d.iso_in   = 1'b0;
      d.iso_seen = 1'b0;
      d.bad      = 1'b0;
    end else if (oct_valid_i && q.busy) begin
      if (q.idx != 8'hff) begin
        d.idx = n;
      end else begin
        d.bad = 1'b1;
      end
      if (!q.dflt && (q.sap == SAP_SET_PRM)) begin
        if (n <= PRM_STD_LEN) begin
          d.stg[4'(n - 8'd1)] = oct_data_i;
        end else begin
          // Each appended block opens with its length; the walk skips whole blocks.
          if (off == 8'd0) begin
            d.blk_end = end_sum[7:0];
            d.iso_in  = 1'b0;
            if ((oct_data_i < 8'd2) || end_sum[8]) begin
              d.bad = 1'b1;
            end
          end else if (off == 8'd1) begin
            d.iso_in = (oct_data_i == ISO_TYPE) &&
                       (q.blk_end - q.blk_base == ISO_LEN - 8'd1);
            if (d.iso_in) begin
              d.iso_seen = 1'b1;
            end
          end else if (q.iso_in) begin
            case (off)
              8'd2: d.bad = q.bad || (oct_data_i != 8'h00);
              8'd3: d.bad = q.bad || (oct_data_i != 8'h00);
              8'd4: d.bad = q.bad || (oct_data_i != ISO_VERSION);
              8'd5, 8'd6, 8'd7, 8'd8: d.stg_dp = {q.stg_dp[23:0], oct_data_i};
              8'd12, 8'd13, 8'd14, 8'd15: d.stg_io = {q.stg_io[23:0], oct_data_i};
              default: d.bad = q.bad;
            endcase
          end
          if ((off != 8'd0) && (n == q.blk_end)) begin
            d.blk_base = n + 8'd1;
          end
        end
      end
    end else if (frm_eof_i && q.busy) begin
      d.busy  = 1'b0;
      d.rsp_v = 1'b1;
      if (q.dflt) begin
        if (q.st == ST_DATA_EXCH && bound) begin
          d.rsp_k = RSP_DATA;
          d.rsp_d = position_i;
        end
      end else begin
        case (q.sap)
          SAP_DIAG: begin
            d.rsp_k = RSP_DIAG;
            d.rsp_d = {q.master, 8'h00,
                       2'b00, q.prm[0][O1_SYNC], q.prm[0][O1_FREEZE],
                       q.prm[0][O1_WD_ON], 1'b1, 1'b0, (q.st == ST_WAIT_PRM),
                       1'b0, q.prm_fault, 3'b000, q.cfg_fault,
                       (q.st != ST_DATA_EXCH), 1'b0};
          end
          SAP_GET_CFG: begin
            d.rsp_k = RSP_CFG;
            d.rsp_d = q.cfg_exp;
          end
          SAP_SET_PRM: begin
            if ((q.st == ST_WAIT_PRM) || (q.st != ST_POWER_ON && bound)) begin
              d.rsp_k = RSP_ACK;
              d.cfg_fault = 1'b0;
              if (prm_ok(q, IDENT_NUMBER)) begin
                d.st        = ST_WAIT_CFG;
                d.master    = q.rmaster;
                d.prm       = q.stg;
                d.tb_dp     = q.stg_dp;
                d.tb_io     = q.stg_io;
                d.iso_on    = q.stg[9][O10_ISOM];
                d.prm_fault = 1'b0;
              end else begin
                d.st        = ST_WAIT_PRM;
                d.master    = MASTER_NONE;
                d.prm_fault = 1'b1;
              end
            end
          end
          SAP_CHK_CFG: begin
            if (bound && (q.st == ST_WAIT_CFG || q.st == ST_DATA_EXCH)) begin
              d.rsp_k = RSP_ACK;
              if (cfg_match) begin
                d.st = ST_DATA_EXCH;
              end else begin
                d.st        = ST_WAIT_PRM;
                d.master    = MASTER_NONE;
                d.cfg_fault = 1'b1;
              end
            end
          end
          default: d.rsp_k = RSP_NONE;
        endcase
      end
      if (d.rsp_k == RSP_NONE) begin
        d.rsp_v = 1'b0;
      end
    end

    // Register port: address phase is latched, write data lands one cycle later.
    ahb_go = hsel_i && hready_i && htrans_i[1];
    case (haddr_i[7:0])
      REG_STATUS:  rmux = {16'h0000, q.master, 3'h0, q.iso_on, q.cfg_fault,
                           q.prm_fault, q.st};
      REG_PRM_A:   rmux = {q.prm[3], q.prm[2], q.prm[1], q.prm[0]};
      REG_PRM_B:   rmux = {q.prm[7], q.prm[6], q.prm[5], q.prm[4]};
      REG_PRM_C:   rmux = {16'h0000, q.prm[9], q.prm[8]};
      REG_TB_DP:   rmux = q.tb_dp;
      REG_TB_IO:   rmux = q.tb_io;
      REG_CFG_EXP: rmux = q.cfg_exp;
      REG_CFG_LEN: rmux = {29'h0, q.cfg_len};
      default:     rmux = 32'h0000_0000;
    endcase
    if (ahb_go && !hwrite_i) begin
      d.rdata = rmux;
    end
    d.wr_pend = ahb_go && hwrite_i;
    if (ahb_go) begin
      d.wr_addr = haddr_i[7:0];
    end
    if (q.wr_pend) begin
      case (q.wr_addr)
        REG_CTRL:    restart   = hwdata_i[0];
        REG_CFG_EXP: d.cfg_exp = hwdata_i;
        REG_CFG_LEN: d.cfg_len = (hwdata_i[2:0] > 3'(CFG_MAX)) ? 3'(CFG_MAX) : hwdata_i[2:0];
        default:     restart   = 1'b0;
      endcase
    end

    // Software restart drops the binding and waits for fresh parameters.
    if (restart) begin
      d.st     = ST_WAIT_PRM;
      d.master = MASTER_NONE;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      q         <= '0;
      q.st      <= ST_POWER_ON;
      q.master  <= MASTER_NONE;
      q.rsp_k   <= RSP_NONE;
      q.blk_base <= BLK_FIRST;
      q.cfg_exp <= CFG_EXP_RST;
      q.cfg_len <= CFG_LEN_RST;
    end else begin
      q <= d;
    end
  end

  assign rsp_valid_o  = q.rsp_v;
  assign rsp_kind_o   = q.rsp_k;
  assign rsp_data_o   = q.rsp_d;
  assign state_o      = q.st;
  assign data_exch_o  = (q.st == ST_DATA_EXCH);
  assign wd_on_o      = q.prm[0][O1_WD_ON];
  assign freeze_req_o = q.prm[0][O1_FREEZE];
  assign sync_req_o   = q.prm[0][O1_SYNC];
  assign iso_mode_o   = q.iso_on;
  assign hreadyout_o  = 1'b1;
  assign hresp_o      = 1'b0;
  assign hrdata_o     = q.rdata;

endmodule

/* File: dpss_startup_assertions.sv */
// Purpose: Concurrent checks on the ports of the DP slave start-up decoder.
// Assumes: One clock domain; asynchronous active-low reset.
// Notes:   Bound to dpss_startup from the testbench top file.
`timescale 1ns/100ps
module dpss_startup_assertions
  import dpss_pkg::*;
(
  input wire logic                  ref_clk_i,
  input wire logic                  rstn_i,
  input wire logic                  frm_sof_i,
  input wire logic [7:0]            frm_sap_i,
  input wire logic                  frm_dflt_i,
  input wire logic                  frm_eof_i,
  input wire logic [31:0]           position_i,
  input wire logic                  rsp_valid_o,
  input wire dpss_pkg::dpss_rsp_t   rsp_kind_o,
  input wire logic [31:0]           rsp_data_o,
  input wire dpss_pkg::dpss_state_t state_o,
  input wire logic                  data_exch_o,
  input wire logic                  hsel_i,
  input wire logic [31:0]           haddr_i,
  input wire logic [1:0]            htrans_i,
  input wire logic                  hwrite_i,
  input wire logic                  hready_i
);
  logic [7:0] sap_q;
  logic       dflt_q;
  logic       wr_q;
  wire        eof_prm = frm_eof_i & ~dflt_q & (sap_q == SAP_SET_PRM);
  wire        eof_cfg = frm_eof_i & ~dflt_q & (sap_q == SAP_CHK_CFG);

  // Remembers the service of the request in flight and a control register write in its data phase.
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      {sap_q, dflt_q, wr_q} <= 10'h000;
    end else begin
      if (frm_sof_i) begin
        {sap_q, dflt_q} <= {frm_sap_i, frm_dflt_i};
      end
      wr_q <= hsel_i & hready_i & htrans_i[1] & hwrite_i & (haddr_i[7:0] == REG_CTRL);
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);

  sequence s_end(logic [7:0] s);
    frm_eof_i && !dflt_q && sap_q == s;
  endsequence
  sequence s_prm_ok;
    (eof_prm && state_o != ST_WAIT_CFG) ##1 state_o == ST_WAIT_CFG;
  endsequence

  property p_one_shot;
    rsp_valid_o |-> $past(frm_eof_i) ##1 !rsp_valid_o;
  endproperty
  property p_diag;
    s_end(SAP_DIAG) |=> rsp_valid_o && rsp_kind_o == RSP_DIAG;
  endproperty
  property p_get_cfg;
    s_end(SAP_GET_CFG) |=> rsp_valid_o && rsp_kind_o == RSP_CFG;
  endproperty
  property p_data;
    rsp_valid_o && rsp_kind_o == RSP_DATA
      |-> $past(state_o) == ST_DATA_EXCH && rsp_data_o == $past(position_i);
  endproperty
  property p_dx_flag;
    data_exch_o == (state_o == ST_DATA_EXCH);
  endproperty
  property p_dx_entry;
    $rose(data_exch_o) |-> $past(eof_cfg);
  endproperty
  property p_hold_prm;
    state_o == ST_WAIT_PRM && !eof_prm |=> state_o == ST_WAIT_PRM;
  endproperty
  property p_hold_cfg;
    state_o == ST_WAIT_CFG && !eof_prm && !eof_cfg && !wr_q |=> state_o == ST_WAIT_CFG;
  endproperty
  property p_power_on;
    state_o == ST_POWER_ON |=> state_o == ST_WAIT_PRM;
  endproperty
  property p_prm_ack;
    s_prm_ok |-> rsp_valid_o && rsp_kind_o == RSP_ACK;
  endproperty

  a_one_shot: assert property (p_one_shot) else $error("answer not one cycle");
  a_diag: assert property (p_diag) else $error("diagnosis not answered");
  a_get_cfg: assert property (p_get_cfg) else $error("config read not answered");
  a_data: assert property (p_data) else $error("cyclic data outside exchange");
  a_dx_flag: assert property (p_dx_flag) else $error("exchange flag wrong");
  a_dx_entry: assert property (p_dx_entry) else $error("exchange without config");
  a_hold_prm: assert property (p_hold_prm) else $error("left wait parameters");
  a_hold_cfg: assert property (p_hold_cfg) else $error("left wait configuration");
  a_power_on: assert property (p_power_on) else $error("stuck after reset");
  a_prm_ack: assert property (p_prm_ack) else $error("accepted parameters not acked");
endmodule

/* File: dpss_master_model.sv */
// Purpose: Behavioural class 1 master that sends start-up requests to the slave.
// Assumes: One clock shared with the slave; octets may be spaced by idle cycles.
// Notes:   Idle header lines carry the inverted header; idle octet lines toggle, so every second idle cycle repeats the last octet.
`timescale 1ns/100ps
module dpss_master_model (
  input  wire logic                ref_clk_i,
  output logic                     frm_sof_o,
  output logic [7:0]               frm_sap_o,
  output logic                     frm_dflt_o,
  output logic [7:0]               frm_mst_o,
  output logic                     oct_valid_o,
  output logic [7:0]               oct_data_o,
  output logic                     frm_eof_o,
  input  wire logic                rsp_valid_i,
  input  wire dpss_pkg::dpss_rsp_t rsp_kind_i,
  input  wire logic [31:0]         rsp_data_i
);
  import dpss_pkg::*;
  initial begin
    {frm_sof_o, frm_dflt_o, oct_valid_o, frm_eof_o} = 4'h0;
    {frm_sap_o, frm_mst_o, oct_data_o} = 24'h0;
  end

  task automatic send(input logic [7:0] sap, input logic dflt, input logic [7:0] mst,
                      input logic [7:0] q[$], input bit slow, output logic v,
                      output logic [2:0] k, output logic [31:0] d);
    int n;
    @(posedge ref_clk_i);
    frm_sof_o <= 1'b1;
    {frm_sap_o, frm_mst_o, frm_dflt_o} <= {sap, mst, dflt};
    foreach (q[i]) begin
      n = slow ? $urandom_range(2) : 0;
      for (int j = 0; j <= n; j++) begin
        @(posedge ref_clk_i);
        {frm_sof_o, oct_valid_o} <= {1'b0, j == n};
        {frm_sap_o, frm_mst_o, frm_dflt_o} <= ~{sap, mst, dflt};
        oct_data_o <= (j == n) ? q[i] : ~oct_data_o;
      end
    end
    @(posedge ref_clk_i);
    {frm_sof_o, oct_valid_o, frm_eof_o} <= 3'b001;
    {frm_sap_o, frm_mst_o, frm_dflt_o} <= ~{sap, mst, dflt};
    oct_data_o <= ~oct_data_o;
    @(posedge ref_clk_i);
    frm_eof_o <= 1'b0;
    #1;
    {v, k, d} = {rsp_valid_i, rsp_kind_i, rsp_data_i};
  endtask
endmodule

/* File: tb_dpss_startup.sv */
// Purpose: Self-checking bench of the DP slave start-up decoder.
// Assumes: Zero-wait register port; answers come one cycle after frame end.
// Notes:   A small model predicts every answer and state; parameter and time base reads are checked against stimulus values, others against constants.
`timescale 1ns/100ps
module tb_dpss_startup;
  import dpss_pkg::*;
  localparam logic [15:0] IDENT = 16'h3c96; // Arbitrary identification value.
  logic        ref_clk_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic        sof, dflt, oval, eof, rv, wd_on, frz, syn, iso_on, dx, hrdy;
  logic [7:0]  sap, mst, odat;
  logic [31:0] pos = 32'h0, hadr = 32'h0, hwd = 32'h0, hrd, cfg, r;
  logic        hsel = 1'b0, hwr = 1'b0;
  logic [1:0]  htr = 2'b00;
  dpss_rsp_t   rk;
  dpss_state_t st_o;
  logic [31:0] rdat;
  logic [7:0]  q[$];
  logic [31:0] tbs[6] = '{32'd375, 32'd750, 32'd1500, 32'd3000, 32'd6000, 32'd12000};
  int          st, bnd, cyc, n_errors = 0, n_tests = 0;

  initial forever #5 ref_clk_i = ~ref_clk_i;

  dpss_master_model i_dpss_master_model (.ref_clk_i(ref_clk_i), .frm_sof_o(sof),
    .frm_sap_o(sap), .frm_dflt_o(dflt), .frm_mst_o(mst), .oct_valid_o(oval),
    .oct_data_o(odat), .frm_eof_o(eof), .rsp_valid_i(rv), .rsp_kind_i(rk),
    .rsp_data_i(rdat));
  dpss_startup #(.IDENT_NUMBER(IDENT)) i_dpss_startup (.ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i), .frm_sof_i(sof), .frm_sap_i(sap), .frm_dflt_i(dflt),
    .frm_master_i(mst), .oct_valid_i(oval), .oct_data_i(odat), .frm_eof_i(eof),
    .position_i(pos), .rsp_valid_o(rv), .rsp_kind_o(rk), .rsp_data_o(rdat),
    .state_o(st_o), .data_exch_o(dx), .wd_on_o(wd_on), .freeze_req_o(frz),
    .sync_req_o(syn), .iso_mode_o(iso_on), .hsel_i(hsel), .haddr_i(hadr),
    .htrans_i(htr), .hwrite_i(hwr), .hsize_i(3'h2), .hwdata_i(hwd), .hready_i(hrdy),
    .hreadyout_o(hrdy), .hresp_o(), .hrdata_o(hrd));

  task automatic wrap_up;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      wrap_up();
    end
  end

  task automatic chk(input logic [31:0] g, e);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge ref_clk_i);
    {hsel, htr, hwr, hadr} <= {1'b1, 2'b10, w, 24'h0, a};
    do @(posedge ref_clk_i); while (hrdy !== 1'b1);
    {hsel, htr, hwd} <= {1'b0, 2'b00, wd};
    do @(posedge ref_clk_i); while (hrdy !== 1'b1);
    rd = hrd;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] m, e);
    logic [31:0] x;
    ahb(1'b0, a, 32'h0, x);
    chk(x & m, e);
  endtask

  task automatic mk(input logic [7:0] o1, o8, o9, o10);
    q = {o1, 8'($urandom_range(255, 1)), 8'($urandom_range(255, 1)), 8'($urandom),
         IDENT[15:8], IDENT[7:0], 8'($urandom), o8, o9, o10};
  endtask

  task automatic iso(input logic [31:0] a, b);
    q = {q, 8'd28, 8'h04, 8'h00, 8'h00, 8'h01, a[31:24], a[23:16], a[15:8], a[7:0],
         8'h00, 8'h01, 8'h01, b[31:24], b[23:16], b[15:8], b[7:0]};
    repeat (12) q.push_back(8'h01);
  endtask

  // Model: predicts the answer and next state, then compares with the slave.
  task automatic tel(input logic [7:0] s, input logic d, input logic [7:0] m, input bit ok);
    logic        v;
    logic [2:0]  k;
    logic [31:0] dat, ed, msk, p;
    int          ek;
    {ek, ed, msk} = {32'd0, 32'h0, 32'hffff_ffff};
    p = $urandom;
    pos <= p;
    if (d) begin
      if (st == 2 && m == bnd) {ek, ed} = {32'(RSP_DATA), p};
    end else case (s)
      SAP_DIAG: begin
        {ek, msk} = {32'(RSP_DIAG), 32'hff00_0502};
        ed = {bnd[7:0], 13'h0, 1'b1, 1'b0, 1'(st == 1), 6'h0, 1'(st != 2), 1'b0};
      end
      SAP_GET_CFG: {ek, ed} = {32'(RSP_CFG), cfg};
      SAP_SET_PRM: if (st == 1 || m == bnd) begin
        {ek, msk} = {32'(RSP_ACK), 32'h0};
        {st, bnd} = {ok ? 32'd3 : 32'd1, ok ? 32'(m) : 32'd255};
      end
      SAP_CHK_CFG: if (st != 1 && m == bnd) begin
        {ek, msk, st, bnd} = {32'(RSP_ACK), 32'h0, ok ? 32'd2 : 32'd1, ok ? bnd : 32'd255};
      end
      default: ;
    endcase
    i_dpss_master_model.send(s, d, m, q, 1'($urandom_range(1)), v, k, dat);
    chk(v, ek != 0);
    if (ek != 0) chk(k, ek);
    if (ek != 0) chk(dat & msk, ed);
    chk(st_o, st);
  endtask

  initial begin
    logic [7:0] o1, o8, o9;
    void'($urandom(32'h2ef6670e));
    {st, bnd, cfg} = {32'd1, 32'd255, 32'h0};
    repeat (5) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    @(posedge ref_clk_i);
    tel(SAP_DIAG, 0, 9, 0);
    tel(SAP_DIAG, 1, 9, 0);
    tel(SAP_GET_CFG, 0, 7, 0);
    for (int i = 0; i < 9; i++) begin
      mk(i == 0 ? 8'h01 : 8'h08, i == 1 ? 8'h00 : 8'h40, i == 2 ? 8'h20 : i == 3 ? 8'h04 : 8'h00,
         i == 4 ? 8'h00 : i == 5 ? 8'h88 : i == 8 ? 8'h18 : 8'h08);
      if (i == 6) q[4] = ~q[4];
      if (i == 7) void'(q.pop_back());
      tel(SAP_SET_PRM, 0, 2, 0);
      rchk(REG_STATUS, 32'h0000_ff07, 32'h0000_ff05);
    end
    r = $urandom;
    o1 = {r[4:0], 3'b000};
    o8 = 8'h40 | (r[15:8] & 8'ha7);
    o9 = {2'b00, o8[7] & r[16], 4'h0, r[17]};
    mk(o1, o8, o9, 8'h08);
    tel(SAP_SET_PRM, 0, 2, 1);
    chk({wd_on, frz, syn}, {o1[3], o1[4], o1[5]});
    rchk(REG_PRM_A, '1, {q[3], q[2], q[1], q[0]});
    rchk(REG_PRM_B, '1, {q[7], q[6], q[5], q[4]});
    rchk(REG_PRM_C, '1, {16'h0, q[9], q[8]});
    rchk(REG_STATUS, 32'h0000_ff07, 32'h0000_0203);
    tel(SAP_SET_PRM, 0, 5, 1);
    cfg = $urandom;
    ahb(1'b1, REG_CFG_EXP, cfg, r);
    ahb(1'b1, REG_CFG_LEN, 32'h2, r);
    q = {cfg[7:0], cfg[15:8]};
    tel(SAP_CHK_CFG, 0, 5, 1);
    tel(SAP_CHK_CFG, 0, 2, 1);
    tel(8'h00, 1, 2, 0);
    tel(8'h00, 1, 5, 0);
    tel(SAP_DIAG, 0, 6, 0);
    tel(SAP_GET_CFG, 0, 7, 0);
    q = {cfg[7:0], cfg[15:8], 8'h00};
    tel(SAP_CHK_CFG, 0, 2, 0);
    rchk(REG_STATUS, 32'h0000_ff0b, 32'h0000_ff09);
    tel(8'h00, 1, 2, 0);
    for (int i = 0; i < 7; i++) begin
      mk(8'h08, 8'h40, 8'h00, 8'h18);
      q = {q, 8'd3, 8'h81, 8'h5a};
      iso(i < 6 ? tbs[i] : 32'd376, tbs[5 - i % 6]);
      tel(SAP_SET_PRM, 0, 2, i < 6);
      if (i < 6) chk(iso_on, 1'b1);
      if (i < 6) rchk(REG_TB_DP, '1, tbs[i]);
      if (i < 6) rchk(REG_TB_IO, '1, tbs[5 - i]);
    end
    mk(8'h08, 8'h40, 8'h00, 8'h08);
    tel(SAP_SET_PRM, 0, 4, 1);
    ahb(1'b1, REG_CTRL, 32'h1, r);
    {st, bnd} = {32'd1, 32'd255};
    rchk(REG_STATUS, 32'h0000_ff03, 32'h0000_ff01);
    rchk(8'h40, '1, 32'h0);
    rchk(REG_CTRL, '1, 32'h0);
    wrap_up();
  end
endmodule

bind dpss_startup dpss_startup_assertions i_dpss_startup_assertions (
  .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .frm_sof_i(frm_sof_i), .frm_sap_i(frm_sap_i),
  .frm_dflt_i(frm_dflt_i), .frm_eof_i(frm_eof_i), .position_i(position_i),
  .rsp_valid_o(rsp_valid_o), .rsp_kind_o(rsp_kind_o), .rsp_data_o(rsp_data_o),
  .state_o(state_o), .data_exch_o(data_exch_o), .hsel_i(hsel_i), .haddr_i(haddr_i),
  .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hready_i(hready_i));
